// [slpm_top.sv]
// Link power management top: ports, power state, presence and activity LED
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "slpm_cfg.svh"
// Contract
// - Acknowledge every drive Partial/Slumber request; never start one as host.
// - Pending work on a sleeping link sends COMWAKE to wake it.
// - Device Sleep is entered only from Slumber.
// - In D3 only configuration accesses succeed; others master abort, yet their writes still update the registers and their reads return data.
// - No interrupt in D3; pending status may interrupt after D0.
// - In D3 ports treated as empty, wires not held.
// - Leaving D3 performs no internal reset; state is kept.
// - Low-power option may switch off wake detection in Slumber.
// - Each port has its own PHY dynamic gating enable.
// - One port enable bit per port; re-enable restarts presence detection.
// - One presence bit per port, set when drive detected.
// - Activity LED pulled low when any port busy, released otherwise.
// - Drive D1/D3 only by forwarding software commands.
// - Exit limits: Partial 10 ns, Slumber 10 ms, Device Sleep 20 ms; Partial is clamped to one 20 ns cycle at 50 MHz.
module slpm_top
  import slpm_pkg::*;
#(
  parameter int PORTS = 8,
  parameter int SLUMBER_EXIT_CYC = `SLPM_SLUMBER_EXIT_CYC,
  parameter int DEVSLP_EXIT_CYC = `SLPM_DEVSLP_EXIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`SLPM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cfg_access,
  output logic master_abort,
  input wire logic irq_in,
  output logic irq_out,
  input wire logic [PORTS-1:0] drive_detect,
  input wire logic [PORTS-1:0] port_busy_flag,
  input wire logic [PORTS-1:0] work_pending,
  input wire logic [PORTS-1:0] devslp_req,
  input wire logic [PORTS-1:0] partial_req,
  input wire logic [PORTS-1:0] slumber_req,
  input wire logic [PORTS-1:0] comwake_det,
  input wire logic [PORTS-1:0] cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic [PORTS-1:0] cmd_fwd_valid,
  output logic [7:0] cmd_fwd_code,
  output logic [PORTS-1:0] pm_ack,
  output logic [PORTS-1:0] comwake_send,
  output logic [PORTS-1:0] devslp,
  output logic [PORTS-1:0] pll_off,
  output logic [PORTS-1:0] phy_gate,
  output logic [PORTS-1:0] port_drive_en,
  output logic activity_led_n_o,
  output logic activity_led_n_oe
);
  initial begin
    if (PORTS < 1 || PORTS > 8) begin
      $error("slpm_top: PORTS must be 1 to 8");
    end
  end
  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end
  logic [PORTS-1:0] det_s1_reg, det_reg, busy_s1_reg, busy_reg, cw_s1_reg, cw_reg;
  logic [PORTS-1:0] pr_s1_reg, pr_reg, sr_s1_reg, sr_reg;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      det_s1_reg <= '0;
      det_reg <= '0;
      busy_s1_reg <= '0;
      busy_reg <= '0;
      cw_s1_reg <= '0;
      cw_reg <= '0;
      pr_s1_reg <= '0;
      pr_reg <= '0;
      sr_s1_reg <= '0;
      sr_reg <= '0;
    end else begin
      det_s1_reg <= drive_detect;
      det_reg <= det_s1_reg;
      busy_s1_reg <= port_busy_flag;
      busy_reg <= busy_s1_reg;
      cw_s1_reg <= comwake_det;
      cw_reg <= cw_s1_reg;
      pr_s1_reg <= partial_req;
      pr_reg <= pr_s1_reg;
      sr_s1_reg <= slumber_req;
      sr_reg <= sr_s1_reg;
    end
  end
  logic [7:0] port_ctl_reg, gating_reg, rdata_reg;
  logic d3_reg, lowpwr_reg;
  wire logic wr_ctl = reg_wr && reg_addr == `SLPM_OFF_PORT_CTL;
  wire logic wr_gate = reg_wr && reg_addr == `SLPM_OFF_GATING;
  wire logic wr_pwr = reg_wr && reg_addr == `SLPM_OFF_POWER;
  wire logic [PORTS-1:0] port_en = port_ctl_reg[PORTS-1:0];
  wire logic [PORTS-1:0] port_live = port_en & {PORTS{!d3_reg}};
  wire logic [PORTS-1:0] present = det_reg & port_live;
  logic [7:0] present_w, busy_w;
  assign present_w = 8'(present);
  assign busy_w = 8'(busy_reg);
  logic [7:0] rd_mux;
  always_comb begin
    if (reg_addr == `SLPM_OFF_PORT_CTL) begin
      rd_mux = port_ctl_reg;
    end else if (reg_addr == `SLPM_OFF_GATING) begin
      rd_mux = gating_reg;
    end else if (reg_addr == `SLPM_OFF_POWER) begin
      rd_mux = {6'h00, lowpwr_reg, d3_reg};
    end else if (reg_addr == `SLPM_OFF_STATUS) begin
      rd_mux = present_w;
    end else if (reg_addr == `SLPM_OFF_BUSY) begin
      rd_mux = busy_w;
    end else begin
      rd_mux = 8'h00;
    end
  end
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_ctl_reg <= `SLPM_PORT_CTL_RST;
      gating_reg <= `SLPM_GATING_RST;
      d3_reg <= 1'b0;
      lowpwr_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      if (wr_ctl) begin
        port_ctl_reg <= reg_wdata;
      end
      if (wr_gate) begin
        gating_reg <= reg_wdata;
      end
      if (wr_pwr) begin
        d3_reg <= reg_wdata[`SLPM_POS_D3];
        lowpwr_reg <= reg_wdata[`SLPM_POS_LOWPWR];
      end
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_reg;
  assign master_abort = d3_reg && (reg_wr || reg_rd) && !cfg_access;
  assign irq_out = irq_in && !d3_reg;
  logic [7:0] fwd_code_reg;
  logic [PORTS-1:0] fwd_valid_reg;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fwd_code_reg <= 8'h00;
      fwd_valid_reg <= '0;
    end else begin
      fwd_valid_reg <= cmd_valid & port_live;
      if (|cmd_valid) begin
        fwd_code_reg <= cmd_code;
      end
    end
  end
  assign cmd_fwd_valid = fwd_valid_reg;
  assign cmd_fwd_code = fwd_code_reg;
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_port
      slpm_link_in_t lin;
      slpm_link_out_t lout;
      assign lin.partial_req = pr_reg[gi];
      assign lin.slumber_req = sr_reg[gi];
      assign lin.comwake_det = cw_reg[gi];
      slpm_port #(
        .SLUMBER_EXIT_CYC(SLUMBER_EXIT_CYC),
        .DEVSLP_EXIT_CYC(DEVSLP_EXIT_CYC)
      ) u_port (
        .clk(clk),
        .rst_n(rst_n_reg),
        .enable(port_live[gi]),
        .low_power(lowpwr_reg),
        .work_pending(work_pending[gi]),
        .devslp_req(devslp_req[gi]),
        .link_in(lin),
        .link_out(lout),
        .state_out(),
        .timeout()
      );
      assign pm_ack[gi] = lout.pm_ack;
      assign comwake_send[gi] = lout.comwake_send;
      assign devslp[gi] = lout.devslp;
      assign pll_off[gi] = lout.pll_off || !port_live[gi];
      assign phy_gate[gi] = gating_reg[gi] && port_live[gi];
    end
  endgenerate
  assign port_drive_en = port_live;
  assign activity_led_n_o = 1'b0;
  assign activity_led_n_oe = |busy_reg;
  a_led_follows_busy: assert property (@(posedge clk) disable iff (!rst_n_reg)
    activity_led_n_oe == (|$past(port_busy_flag, 2)))
    else $error("activity LED does not track busy");
  a_d3_no_irq: assert property (@(posedge clk) disable iff (!rst_n_reg)
    d3_reg |-> !irq_out)
    else $error("interrupt raised in D3");
  a_d3_abort: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (d3_reg && reg_rd && !cfg_access) |-> master_abort)
    else $error("memory access in D3 not aborted");
  a_d3_keeps_ctl: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (d3_reg && !wr_ctl) |=> port_ctl_reg == $past(port_ctl_reg))
    else $error("port control lost in D3");
  a_disabled_absent: assert property (@(posedge clk) disable iff (!rst_n_reg)
    !port_live[0] |-> !present[0])
    else $error("disabled port reports presence");
endmodule
`default_nettype wire

// [slpm_cfg.svh]
// Offsets, field positions, reset values and timing counts for the link power block
`ifndef SLPM_CFG_SVH
`define SLPM_CFG_SVH
`define SLPM_ADDR_W 4
`define SLPM_OFF_PORT_CTL 4'h0
`define SLPM_OFF_GATING 4'h1
`define SLPM_OFF_POWER 4'h2
`define SLPM_OFF_STATUS 4'h3
`define SLPM_OFF_BUSY 4'h4
`define SLPM_POS_D3 0
`define SLPM_POS_LOWPWR 1
`define SLPM_PORT_CTL_RST 8'h00
`define SLPM_GATING_RST 8'h00
`define SLPM_CLK_MHZ 50
`define SLPM_PARTIAL_EXIT_NS 10
`define SLPM_SLUMBER_EXIT_MS 10
`define SLPM_DEVSLP_EXIT_MS 20
`define SLPM_PARTIAL_EXIT_CYC ((`SLPM_PARTIAL_EXIT_NS * `SLPM_CLK_MHZ) / 1000 < 1 ? 1 : (`SLPM_PARTIAL_EXIT_NS * `SLPM_CLK_MHZ) / 1000)
`define SLPM_SLUMBER_EXIT_CYC (`SLPM_SLUMBER_EXIT_MS * `SLPM_CLK_MHZ * 1000)
`define SLPM_DEVSLP_EXIT_CYC (`SLPM_DEVSLP_EXIT_MS * `SLPM_CLK_MHZ * 1000)
`endif

// [slpm_pkg.sv]
// Types for the link power block
`default_nettype none
package slpm_pkg;
  typedef enum logic [2:0] {
    SLPM_ACTIVE = 3'b000,
    SLPM_PARTIAL = 3'b001,
    SLPM_SLUMBER = 3'b010,
    SLPM_DEVSLP = 3'b011,
    SLPM_WAKE = 3'b100
  } slpm_state_t;
  typedef struct packed {
    logic partial_req;
    logic slumber_req;
    logic comwake_det;
  } slpm_link_in_t;
  typedef struct packed {
    logic pm_ack;
    logic comwake_send;
    logic devslp;
    logic pll_off;
  } slpm_link_out_t;
endpackage
`default_nettype wire

// [slpm_port.sv]
// Per-port link power state machine
`timescale 1ns/100ps
`default_nettype none
`include "slpm_cfg.svh"
module slpm_port
  import slpm_pkg::*;
#(
  parameter int SLUMBER_EXIT_CYC = `SLPM_SLUMBER_EXIT_CYC,
  parameter int DEVSLP_EXIT_CYC = `SLPM_DEVSLP_EXIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic low_power,
  input wire logic work_pending,
  input wire logic devslp_req,
  input wire slpm_link_in_t link_in,
  output slpm_link_out_t link_out,
  output logic [2:0] state_out,
  output logic timeout
);
  localparam int PART_CYC = `SLPM_PARTIAL_EXIT_CYC;
  initial begin
    if (SLUMBER_EXIT_CYC < 1 || DEVSLP_EXIT_CYC < SLUMBER_EXIT_CYC) begin
      $error("slpm_port: bad exit counts");
    end
  end
  slpm_state_t state_reg, state_next;
  slpm_state_t from_reg;
  logic [31:0] wait_reg;
  logic ack_reg, wake_reg, timeout_reg;
  wire logic det_ok = link_in.comwake_det && !(low_power && state_reg == SLPM_SLUMBER);
  wire logic [31:0] limit = (from_reg == SLPM_PARTIAL) ? 32'(PART_CYC) :
                           (from_reg == SLPM_DEVSLP) ? 32'(DEVSLP_EXIT_CYC) : 32'(SLUMBER_EXIT_CYC);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLPM_ACTIVE: begin
        if (link_in.slumber_req) begin
          state_next = SLPM_SLUMBER;
        end else if (link_in.partial_req) begin
          state_next = SLPM_PARTIAL;
        end
      end
      SLPM_PARTIAL: begin
        if (work_pending || det_ok) begin
          state_next = SLPM_WAKE;
        end
      end
      SLPM_SLUMBER: begin
        if (work_pending || det_ok) begin
          state_next = SLPM_WAKE;
        end else if (devslp_req) begin
          state_next = SLPM_DEVSLP;
        end
      end
      SLPM_DEVSLP: begin
        if (work_pending || link_in.comwake_det) begin
          state_next = SLPM_WAKE;
        end
      end
      SLPM_WAKE: begin
        if (wait_reg >= limit - 32'h1) begin
          state_next = SLPM_ACTIVE;
        end
      end
      default: state_next = SLPM_ACTIVE;
    endcase
    if (!enable) begin
      state_next = SLPM_ACTIVE;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SLPM_ACTIVE;
      from_reg <= SLPM_ACTIVE;
      wait_reg <= 32'h0;
      ack_reg <= 1'b0;
      wake_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg != SLPM_WAKE) begin
        from_reg <= state_reg;
      end
      wait_reg <= (state_reg == SLPM_WAKE && state_next == SLPM_WAKE) ? wait_reg + 32'h1 : 32'h0;
      ack_reg <= (state_reg == SLPM_ACTIVE) && (state_next == SLPM_PARTIAL || state_next == SLPM_SLUMBER);
      wake_reg <= (state_reg != SLPM_WAKE) && (state_next == SLPM_WAKE);
      timeout_reg <= (state_reg == SLPM_WAKE) && (state_next == SLPM_ACTIVE);
    end
  end
  assign link_out.pm_ack = ack_reg;
  assign link_out.comwake_send = wake_reg;
  assign link_out.devslp = (state_reg == SLPM_DEVSLP);
  assign link_out.pll_off = low_power && (state_reg == SLPM_SLUMBER);
  assign state_out = state_reg;
  assign timeout = timeout_reg;
  a_devslp_from_slumber: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg != SLPM_DEVSLP && state_next == SLPM_DEVSLP) |-> state_reg == SLPM_SLUMBER)
    else $error("device sleep entered from a state other than slumber");
  a_ack_follows_req: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SLPM_ACTIVE && state_next == SLPM_SLUMBER) |=> link_out.pm_ack)
    else $error("power request not acknowledged");
  a_wake_sends_comwake: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SLPM_PARTIAL && work_pending && enable) |=> link_out.comwake_send)
    else $error("no comwake for pending work");
endmodule
`default_nettype wire

// [slpm_drive_model.sv]
// Drive-side model of the serial link, one lane per port
`timescale 1ns/100ps
`default_nettype none
module slpm_drive_model #(
  parameter int PORTS = 8
) (
  input wire logic clk,
  input wire logic [PORTS-1:0] want_partial,
  input wire logic [PORTS-1:0] want_slumber,
  input wire logic [PORTS-1:0] want_wake,
  input wire logic [PORTS-1:0] outstanding,
  input wire logic [PORTS-1:0] pm_ack,
  input wire logic [PORTS-1:0] comwake_send,
  output logic [PORTS-1:0] partial_req,
  output logic [PORTS-1:0] slumber_req,
  output logic [PORTS-1:0] comwake_det
);
  logic [PORTS-1:0] p_r = '0, s_r = '0, w_r = '0, acked = '0, woke = '0, asleep = '0;
  always @(posedge clk) begin
    acked <= (acked | pm_ack) & (want_partial | want_slumber);
    // Request held until the host answers
    p_r <= want_partial & ~(acked | pm_ack);
    s_r <= want_slumber & ~(acked | pm_ack);
    asleep <= (asleep | (pm_ack & s_r)) & ~comwake_send;
    woke <= (woke | comwake_send) & want_wake;
    // Wake only by COMWAKE, never while idle in slumber
    w_r <= want_wake & ~(woke | comwake_send) & (outstanding | ~asleep);
  end
  assign partial_req = p_r;
  assign slumber_req = s_r;
  assign comwake_det = w_r;
endmodule
`default_nettype wire

// [slpm_top_tb.sv]
// Testbench for the link power block
`timescale 1ns/100ps
`default_nettype none
module slpm_top_tb;
  logic clk = 1'b0, reset_n = 1'b0, got, got2;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, d, code = 8'h00, fcode;
  logic wr_s = 1'b0, rd_s = 1'b0, cfg = 1'b0, irq_in = 1'b0, irq_out, mabort, led_o, led_oe;
  logic [7:0] det = 8'h00, busy = 8'h00, work = 8'h00, dsreq = 8'h00, cmdv = 8'h00, fvalid;
  logic [7:0] wp = 8'h00, ws = 8'h00, ww = 8'h00, outs = 8'h00;
  logic [7:0] preq, sreq, cwd, ack, cws, dslp, pll, gate, drv_en;
  int n_fail = 0, check_count = 0, cyc = 0;
  slpm_top #(.PORTS(8), .SLUMBER_EXIT_CYC(20), .DEVSLP_EXIT_CYC(40)) slpm_top_i (
    .clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdata), .cfg_access(cfg), .master_abort(mabort), .irq_in(irq_in), .irq_out(irq_out),
    .drive_detect(det), .port_busy_flag(busy), .work_pending(work), .devslp_req(dsreq),
    .partial_req(preq), .slumber_req(sreq), .comwake_det(cwd), .cmd_valid(cmdv), .cmd_code(code),
    .cmd_fwd_valid(fvalid), .cmd_fwd_code(fcode), .pm_ack(ack), .comwake_send(cws), .devslp(dslp),
    .pll_off(pll), .phy_gate(gate), .port_drive_en(drv_en), .activity_led_n_o(led_o),
    .activity_led_n_oe(led_oe));
  slpm_drive_model #(.PORTS(8)) slpm_drive_model_i (.clk(clk), .want_partial(wp), .want_slumber(ws),
    .want_wake(ww), .outstanding(outs), .pm_ack(ack), .comwake_send(cws), .partial_req(preq),
    .slumber_req(sreq), .comwake_det(cwd));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // Port 0 pulse or level seen within n cycles
  task automatic watch(input int which, input int n, output logic hit);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((which == 0 ? ack[0] : which == 1 ? cws[0] : dslp[0]) === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic t_regs();
    reg_read(4'h0, d);
    chk("port_ctl reset", d, 8'h00);
    reg_read(4'h1, d);
    chk("gating reset", d, 8'h00);
    reg_write(4'h7, 8'hFF);
    reg_read(4'h7, d);
    chk("unmapped", d, 8'h00);
    reg_write(4'h1, 8'h5A);
    reg_read(4'h1, d);
    chk("gating", d, 8'h5A);
    @(posedge clk);
    det <= 8'hA5;
    reg_write(4'h0, 8'hFE);
    reg_read(4'h3, d);
    chk("presence masked", d, 8'hA4);
    reg_write(4'h0, 8'hFF);
    reg_read(4'h3, d);
    chk("presence", d, 8'hA5);
    chk("drive enables", drv_en, 8'hFF);
    chk("phy gating", gate, 8'h5A);
    $display("regs done");
  endtask
  task automatic t_link();
    watch(0, 10, got);
    chk("no host request", got, 1'b0);
    @(posedge clk);
    ws <= 8'h01;
    watch(0, 6, got);
    chk("slumber ack", got, 1'b1);
    @(posedge clk);
    ws <= 8'h00;
    outs <= 8'h01;
    ww <= 8'h01;
    watch(1, 6, got);
    chk("wake reply", got, 1'b1);
    @(posedge clk);
    ww <= 8'h00;
    wp <= 8'h01;
    watch(0, 14, got);
    chk("exit early", got, 1'b0);
    watch(0, 14, got);
    chk("exit done", got, 1'b1);
    @(posedge clk);
    wp <= 8'h00;
    work <= 8'h01;
    watch(1, 4, got);
    chk("host wake", got, 1'b1);
    @(posedge clk);
    ws <= 8'h01;
    fork
      watch(0, 8, got);
      watch(1, 8, got2);
    join
    chk("ack while busy", got, 1'b1);
    chk("wake after ack", got2, 1'b1);
    @(posedge clk);
    ws <= 8'h00;
    work <= 8'h00;
    repeat (20) @(posedge clk);
    $display("link done");
  endtask
  task automatic t_devslp();
    @(posedge clk);
    dsreq <= 8'h01;
    watch(2, 6, got);
    chk("devslp active", got, 1'b0);
    @(posedge clk);
    ws <= 8'h01;
    watch(2, 8, got);
    chk("devslp slumber", got, 1'b1);
    @(posedge clk);
    ws <= 8'h00;
    dsreq <= 8'h00;
    ww <= 8'h01;
    watch(1, 6, got);
    chk("devslp wake", got, 1'b1);
    @(posedge clk);
    ww <= 8'h00;
    repeat (45) @(posedge clk);
    #1 chk("devslp left", dslp[0], 1'b0);
    $display("devslp done");
  endtask
  task automatic t_lowpwr();
    reg_write(4'h2, 8'h02);
    @(posedge clk);
    ws <= 8'h01;
    watch(0, 6, got);
    chk("lp ack", got, 1'b1);
    @(posedge clk);
    ws <= 8'h00;
    ww <= 8'h01;
    watch(1, 10, got);
    chk("lp wake lost", got, 1'b0);
    chk("pll off", pll, 8'h01);
    @(posedge clk);
    work <= 8'h01;
    watch(1, 4, got);
    chk("lp host wake", got, 1'b1);
    @(posedge clk);
    work <= 8'h00;
    ww <= 8'h00;
    reg_write(4'h2, 8'h00);
    $display("lowpwr done");
  endtask
  task automatic t_led_cmd();
    @(posedge clk);
    busy <= 8'h10;
    cmdv <= 8'h02;
    code <= 8'hE0;
    @(posedge clk);
    cmdv <= 8'h00;
    #1 chk("fwd valid", fvalid, 8'h02);
    chk("fwd code", fcode, 8'hE0);
    repeat (3) @(posedge clk);
    #1 chk("led oe", led_oe, 1'b1);
    chk("led level", led_o, 1'b0);
    reg_read(4'h4, d);
    chk("busy status", d, 8'h10);
    @(posedge clk);
    busy <= 8'h00;
    repeat (4) @(posedge clk);
    #1 chk("led off", led_oe, 1'b0);
    $display("led done");
  endtask
  task automatic t_d3();
    @(posedge clk);
    irq_in <= 1'b1;
    @(posedge clk);
    #1 chk("irq D0", irq_out, 1'b1);
    reg_write(4'h2, 8'h01);
    @(posedge clk);
    addr <= 4'h0;
    rd_s <= 1'b1;
    #1 chk("abort", mabort, 1'b1);
    @(posedge clk);
    cfg <= 1'b1;
    addr <= 4'h2;
    #1 chk("cfg ok", mabort, 1'b0);
    chk("irq D3", irq_out, 1'b0);
    chk("wires off", drv_en, 8'h00);
    chk("pll d3", pll, 8'hFF);
    chk("gating d3", gate, 8'h00);
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk("cfg read", rdata, 8'h01);
    reg_write(4'h2, 8'h00);
    reg_read(4'h0, d);
    chk("state kept", d, 8'hFF);
    chk("irq back", irq_out, 1'b1);
    $display("d3 done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_link();
    t_devslp();
    t_lowpwr();
    t_led_cmd();
    t_d3();
    tally_and_finish();
  end
endmodule
`default_nettype wire
